// *** msbc_host_model.sv ***
// host controller model: select, reset, low power and management strobes
`timescale 1ns/1ns
module msbc_host_model (
    input wire logic clk_sys_i,
    input wire logic mgmt_ack_i,
    input wire logic [7:0] mgmt_rdata_i,
    output logic module_select_n_o,
    output logic module_reset_n_o,
    output logic low_power_request_o,
    output msbc_pkg::msbc_mgmt_req_s mgmt_req_o
);
    // open pins read as their pad pull-ups
    initial
    begin
        module_select_n_o = 1'b1;
        module_reset_n_o = 1'b1;
        low_power_request_o = 1'b1;
        mgmt_req_o = '0;
    end

    // ------------------------------------------------------------
    // one strobed transfer, select released afterwards
    // ------------------------------------------------------------
    task automatic xfer(input logic sel_n, input logic wr, input logic [7:0] addr,
        input logic [7:0] wdata, output logic acked, output logic [7:0] rdata);
        @(posedge clk_sys_i);
        #1;
        module_select_n_o = sel_n;
        mgmt_req_o = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        @(posedge clk_sys_i);
        #1;
        // released lines no longer show the last value
        mgmt_req_o = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
        module_select_n_o = 1'b1;
        acked = mgmt_ack_i;
        rdata = mgmt_rdata_i;
    endtask
endmodule

// *** msbc_pkg.sv ***
// constants and carrier types for the module sideband control block
package msbc_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int LANES = 4;
    localparam int NUM_MON = 14;
    localparam int NUM_KIND = 5;
    localparam int NUM_CTRL = 9;
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_RESET_MIN_NS = 10000;
    localparam int T_INIT_NS = 2000;
    localparam int RESET_MIN_CYC = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYC = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // management byte map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam int NOT_READY_BIT = 0;
    localparam logic [7:0] ADDR_SIG_ABSENT = 8'h03;
    localparam logic [7:0] ADDR_LOCK_LOST = 8'h04;
    localparam logic [7:0] ADDR_TX_FAULT = 8'h05;
    localparam logic [7:0] ADDR_ALARM_LO = 8'h06;
    localparam logic [7:0] ADDR_ALARM_HI = 8'h07;
    localparam logic [7:0] ADDR_WARN_LO = 8'h08;
    localparam logic [7:0] ADDR_WARN_HI = 8'h09;
    localparam logic [7:0] ADDR_MON_BASE = 8'h16;
    localparam logic [7:0] MON_SPAN = 8'h1c;
    localparam int PWR_OVERRIDE_BIT = 0;
    localparam int PWR_SELECT_BIT = 1;
    // mask byte bits, a one masks the group
    localparam int MASK_SIG_ABSENT = 0;
    localparam int MASK_LOCK_LOST = 1;
    localparam int MASK_TX_FAULT = 2;
    localparam int MASK_ALARM = 3;
    localparam int MASK_WARN = 4;

    // ctrl entries: power, clock recovery, mask, tx eq x2, rx emph x2, rx amp x2
    localparam int CI_POWER = 0;
    localparam int CI_CLKREC = 1;
    localparam int CI_MASK = 2;
    localparam int CI_TX_EQ = 3;
    localparam int CI_RX_EMPH = 5;
    localparam int CI_RX_AMP = 7;
    localparam logic [7:0] CTRL_ADDR [NUM_CTRL] =
        '{8'h5d, 8'h62, 8'h64, 8'hea, 8'heb, 8'hec, 8'hed, 8'hee, 8'hef};
    localparam logic [7:0] CTRL_RST [NUM_CTRL] =
        '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // ----------------------------------------------------------------
    // fixed monitor thresholds per kind: rx pwr, tx pwr, bias, vcc, temp
    // ----------------------------------------------------------------
    localparam logic [15:0] ALARM_HI [NUM_KIND] = '{16'hf000, 16'hf000, 16'hf000, 16'h8d00, 16'h5000};
    localparam logic [15:0] ALARM_LO [NUM_KIND] = '{16'h0010, 16'h0010, 16'h0100, 16'h7500, 16'h0000};
    localparam logic [15:0] WARN_HI [NUM_KIND] = '{16'he000, 16'he000, 16'he000, 16'h8a00, 16'h4600};
    localparam logic [15:0] WARN_LO [NUM_KIND] = '{16'h0020, 16'h0020, 16'h0200, 16'h7800, 16'h0500};
    localparam int MON_KIND [NUM_MON] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 4};

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [LANES-1:0] signal_absent_flag;
        logic [LANES-1:0] lock_lost_flag;
        logic [LANES-1:0] tx_fault;
    } msbc_lane_flags_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msbc_mgmt_req_s;

    typedef struct packed {
        logic [LANES-1:0] clock_recovery_tx_en;
        logic [LANES-1:0] clock_recovery_rx_en;
        logic [15:0] tx_eq;
        logic [15:0] rx_emph;
        logic [15:0] rx_amp;
    } msbc_link_ctrl_s;

endpackage

// *** msbc_reset_qualify.sv ***
// qualifies the module reset pin against the least pulse length
`timescale 1ns/1ns
module msbc_reset_qualify #(
    parameter int MIN_CYC = msbc_pkg::RESET_MIN_CYC
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic module_reset_n_i,
    output logic reset_held_o
);

    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    logic reset_held_r;
    wire logic reached_w = (low_cnt_r >= 16'(MIN_CYC));

    // count low cycles, saturating at the threshold
    assign low_cnt_nxt = module_reset_n_i ? 16'h0000 :
                         (reached_w ? low_cnt_r : low_cnt_r + 16'h0001);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_cnt_r <= 16'h0000;
            reset_held_r <= 1'b0;
        end
        else
        begin
            low_cnt_r <= low_cnt_nxt;
            reset_held_r <= reached_w && !module_reset_n_i;
        end
    end

    assign reset_held_o = reset_held_r;

endmodule

// *** msbc_sideband.sv ***
// sideband control, status and interrupt logic of the pluggable module
//
// Overview of operation
// - presence output held low permanently
// - management access only while select held low
// - long reset pulse restores all default settings
// - power-up runs reset-complete sequence unaided
// - start in low power, management active
// - high power by pin low or override bits
// - interrupt pulled low on fault or alarm
// - interrupt released after clean not-ready read
// - clock recovery on by default, software disables
// - lane flags readable and merged onto interrupt
// - monitor thresholds fixed, not writable
// - per-lane power and bias, module supply and temperature readable
// - programmable equalization, amplitude, emphasis
`timescale 1ns/1ns
module msbc_sideband #(
    parameter int LANES = msbc_pkg::LANES,
    parameter int NUM_MON = msbc_pkg::NUM_MON
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic module_select_n_i,
    input wire logic module_reset_n_i,
    input wire logic low_power_request_i,
    input wire msbc_pkg::msbc_lane_flags_s lane_flags_i,
    input wire logic [NUM_MON-1:0][15:0] diag_monitor_i,
    input wire msbc_pkg::msbc_mgmt_req_s mgmt_req_i,
    output logic mgmt_ack_o,
    output logic [7:0] mgmt_rdata_o,
    output logic module_present_n_o,
    output logic interrupt_n_o,
    output logic interrupt_n_oe_n_o,
    output logic high_power_o,
    output msbc_pkg::msbc_link_ctrl_s link_ctrl_o
);

    // ----------------------------------------------------------------
    // state and storage
    // ----------------------------------------------------------------
    typedef enum logic {MSBC_INIT, MSBC_READY} msbc_state_e;

    msbc_state_e state_r;
    msbc_state_e state_nxt;
    logic [15:0] init_cnt_r;
    logic not_ready_r;
    logic reset_done_r;
    logic [7:0] ctrl_r [msbc_pkg::NUM_CTRL];
    msbc_pkg::msbc_lane_flags_s flags_r;
    logic [NUM_MON-1:0] alarm_r;
    logic [NUM_MON-1:0] warn_r;
    logic ack_r;
    logic [7:0] rdata_r;
    logic present_n_r;
    logic int_drive_r;
    logic high_power_r;
    logic reset_held_w;

    msbc_reset_qualify #(
        .MIN_CYC(msbc_pkg::RESET_MIN_CYC)
    ) u_reset_qualify (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .module_reset_n_i(module_reset_n_i),
        .reset_held_o(reset_held_w)
    );

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    wire logic accept_w = mgmt_req_i.valid && !module_select_n_i;
    wire logic rd_w = accept_w && !mgmt_req_i.write;
    wire logic wr_w = accept_w && mgmt_req_i.write && !reset_held_w;
    wire logic [7:0] addr_w = mgmt_req_i.addr;
    wire logic rd_status_w = rd_w && (addr_w == msbc_pkg::ADDR_STATUS);
    wire logic rd_sa_w = rd_w && (addr_w == msbc_pkg::ADDR_SIG_ABSENT);
    wire logic rd_ll_w = rd_w && (addr_w == msbc_pkg::ADDR_LOCK_LOST);
    wire logic rd_tf_w = rd_w && (addr_w == msbc_pkg::ADDR_TX_FAULT);
    wire logic rd_alarm_w = rd_w && ((addr_w == msbc_pkg::ADDR_ALARM_LO) ||
                                     (addr_w == msbc_pkg::ADDR_ALARM_HI));
    wire logic rd_warn_w = rd_w && ((addr_w == msbc_pkg::ADDR_WARN_LO) ||
                                    (addr_w == msbc_pkg::ADDR_WARN_HI));
    wire logic [7:0] mon_off_w = addr_w - msbc_pkg::ADDR_MON_BASE;
    wire logic mon_hit_w = (addr_w >= msbc_pkg::ADDR_MON_BASE) && (mon_off_w < msbc_pkg::MON_SPAN);
    wire logic [15:0] mon_word_w = mon_hit_w ? diag_monitor_i[mon_off_w[4:1]] : 16'h0000;
    wire logic [7:0] mon_byte_w = mon_off_w[0] ? mon_word_w[7:0] : mon_word_w[15:8];
    wire logic monitoring_w = (state_r == MSBC_READY);
    wire logic [7:0] mask_w = ctrl_r[msbc_pkg::CI_MASK];
    wire logic [7:0] pwr_w = ctrl_r[msbc_pkg::CI_POWER];

    // ----------------------------------------------------------------
    // control bytes, write only these; thresholds are constants
    // ----------------------------------------------------------------
    logic [msbc_pkg::NUM_CTRL-1:0] ctrl_hit_w;
    logic [7:0] ctrl_rd_w [msbc_pkg::NUM_CTRL];

    for (genvar gi = 0; gi < msbc_pkg::NUM_CTRL; gi++)
    begin : g_ctrl
        assign ctrl_hit_w[gi] = (addr_w == msbc_pkg::CTRL_ADDR[gi]);
        assign ctrl_rd_w[gi] = ctrl_hit_w[gi] ? ctrl_r[gi] : 8'h00;
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                ctrl_r[gi] <= msbc_pkg::CTRL_RST[gi];
            else if (reset_held_w)
                ctrl_r[gi] <= msbc_pkg::CTRL_RST[gi];
            else if (wr_w && ctrl_hit_w[gi])
                ctrl_r[gi] <= mgmt_req_i.wdata;
        end
    end

    logic [7:0] ctrl_byte_w;
    always_comb
    begin
        ctrl_byte_w = 8'h00;
        for (int i = 0; i < msbc_pkg::NUM_CTRL; i++)
            ctrl_byte_w = ctrl_byte_w | ctrl_rd_w[i];
    end

    // ----------------------------------------------------------------
    // monitor flags against fixed thresholds
    // ----------------------------------------------------------------
    logic [NUM_MON-1:0] alarm_set_w;
    logic [NUM_MON-1:0] warn_set_w;
    for (genvar gm = 0; gm < NUM_MON; gm++)
    begin : g_mon
        localparam int K = msbc_pkg::MON_KIND[gm];
        assign alarm_set_w[gm] = monitoring_w &&
            ((diag_monitor_i[gm] > msbc_pkg::ALARM_HI[K]) ||
             (diag_monitor_i[gm] < msbc_pkg::ALARM_LO[K]));
        assign warn_set_w[gm] = monitoring_w &&
            ((diag_monitor_i[gm] > msbc_pkg::WARN_HI[K]) ||
             (diag_monitor_i[gm] < msbc_pkg::WARN_LO[K]));
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] rd_byte_w;
    always_comb
    begin
        rd_byte_w = ctrl_byte_w | mon_byte_w;
        unique case (addr_w)
            msbc_pkg::ADDR_STATUS: rd_byte_w = {7'h00, not_ready_r};
            msbc_pkg::ADDR_SIG_ABSENT: rd_byte_w = 8'(flags_r.signal_absent_flag);
            msbc_pkg::ADDR_LOCK_LOST: rd_byte_w = 8'(flags_r.lock_lost_flag);
            msbc_pkg::ADDR_TX_FAULT: rd_byte_w = 8'(flags_r.tx_fault);
            msbc_pkg::ADDR_ALARM_LO: rd_byte_w = alarm_r[7:0];
            msbc_pkg::ADDR_ALARM_HI: rd_byte_w = 8'(alarm_r[NUM_MON-1:8]);
            msbc_pkg::ADDR_WARN_LO: rd_byte_w = warn_r[7:0];
            msbc_pkg::ADDR_WARN_HI: rd_byte_w = 8'(warn_r[NUM_MON-1:8]);
            default: rd_byte_w = ctrl_byte_w | mon_byte_w;
        endcase
    end

    // ----------------------------------------------------------------
    // reset sequence
    // ----------------------------------------------------------------
    wire logic init_done_w = (state_r == MSBC_INIT) && !reset_held_w &&
                             (init_cnt_r == 16'(msbc_pkg::INIT_CYC - 1));

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            MSBC_INIT: if (init_done_w) state_nxt = MSBC_READY;
            MSBC_READY: if (reset_held_w) state_nxt = MSBC_INIT;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r <= MSBC_INIT;
            init_cnt_r <= 16'h0000;
            not_ready_r <= 1'b1;
            reset_done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            init_cnt_r <= (state_r == MSBC_READY || reset_held_w) ? 16'h0000 :
                          init_cnt_r + 16'h0001;
            not_ready_r <= reset_held_w || (not_ready_r && !init_done_w);
            if (init_done_w || reset_held_w)
                reset_done_r <= init_done_w;
            else if (rd_status_w && !not_ready_r)
                reset_done_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // latched flags, cleared on read, a new event wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flags_r <= '0;
            alarm_r <= '0;
            warn_r <= '0;
        end
        else if (reset_held_w)
        begin
            flags_r <= '0;
            alarm_r <= '0;
            warn_r <= '0;
        end
        else
        begin
            flags_r.signal_absent_flag <= (rd_sa_w ? '0 : flags_r.signal_absent_flag) |
                (monitoring_w ? lane_flags_i.signal_absent_flag : '0);
            flags_r.lock_lost_flag <= (rd_ll_w ? '0 : flags_r.lock_lost_flag) |
                (monitoring_w ? lane_flags_i.lock_lost_flag : '0);
            flags_r.tx_fault <= (rd_tf_w ? '0 : flags_r.tx_fault) |
                (monitoring_w ? lane_flags_i.tx_fault : '0);
            alarm_r <= (rd_alarm_w ? '0 : alarm_r) | alarm_set_w;
            warn_r <= (rd_warn_w ? '0 : warn_r) | warn_set_w;
        end
    end

    // ----------------------------------------------------------------
    // pins and answers
    // ----------------------------------------------------------------
    wire logic flag_int_w =
        (|flags_r.signal_absent_flag && !mask_w[msbc_pkg::MASK_SIG_ABSENT]) ||
        (|flags_r.lock_lost_flag && !mask_w[msbc_pkg::MASK_LOCK_LOST]) ||
        (|flags_r.tx_fault && !mask_w[msbc_pkg::MASK_TX_FAULT]) ||
        (|alarm_r && !mask_w[msbc_pkg::MASK_ALARM]) ||
        (|warn_r && !mask_w[msbc_pkg::MASK_WARN]);
    wire logic hp_req_w = !low_power_request_i ||
        (pwr_w[msbc_pkg::PWR_OVERRIDE_BIT] && pwr_w[msbc_pkg::PWR_SELECT_BIT]);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
            present_n_r <= 1'b0;
            int_drive_r <= 1'b0;
            high_power_r <= 1'b0;
        end
        else
        begin
            ack_r <= accept_w;
            rdata_r <= rd_w ? rd_byte_w : rdata_r;
            present_n_r <= 1'b0;
            int_drive_r <= reset_done_r || flag_int_w;
            high_power_r <= !not_ready_r && hp_req_w;
        end
    end

    assign mgmt_ack_o = ack_r;
    assign mgmt_rdata_o = rdata_r;
    assign module_present_n_o = present_n_r;
    assign interrupt_n_o = 1'b0 & present_n_r;
    assign interrupt_n_oe_n_o = !int_drive_r;
    assign high_power_o = high_power_r;
    assign link_ctrl_o.clock_recovery_tx_en = ctrl_r[msbc_pkg::CI_CLKREC][7:4];
    assign link_ctrl_o.clock_recovery_rx_en = ctrl_r[msbc_pkg::CI_CLKREC][3:0];
    assign link_ctrl_o.tx_eq = {ctrl_r[msbc_pkg::CI_TX_EQ + 1], ctrl_r[msbc_pkg::CI_TX_EQ]};
    assign link_ctrl_o.rx_emph = {ctrl_r[msbc_pkg::CI_RX_EMPH + 1], ctrl_r[msbc_pkg::CI_RX_EMPH]};
    assign link_ctrl_o.rx_amp = {ctrl_r[msbc_pkg::CI_RX_AMP + 1], ctrl_r[msbc_pkg::CI_RX_AMP]};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_PRESENT_LOW: assert property (module_present_n_o == 1'b0)
        else $error("presence output not low");
    AST_SELECT_GATE: assert property (mgmt_ack_o |-> $past(!module_select_n_i))
        else $error("answer given without select");
    AST_RESET_DEFAULTS: assert property (reset_held_w |=>
        (link_ctrl_o.clock_recovery_tx_en == 4'hf) && (pwr_w == 8'h00) && not_ready_r)
        else $error("settings not restored by reset");
    AST_POWERUP_DONE: assert property ($fell(not_ready_r) |-> reset_done_r ##1 !interrupt_n_oe_n_o)
        else $error("reset completion not signalled");
    AST_LOW_POWER_START: assert property (not_ready_r |=> !high_power_o)
        else $error("high power while not ready");
    AST_HIGH_POWER_CAUSE: assert property ($rose(high_power_o) |-> $past(hp_req_w))
        else $error("high power without request");
    AST_INT_ON_FLAG: assert property (flag_int_w |=> !interrupt_n_oe_n_o)
        else $error("unmasked flag did not drive interrupt");
    AST_INT_RELEASE: assert property ((rd_status_w && !not_ready_r && !reset_held_w)
        |=> !reset_done_r)
        else $error("status read did not release completion");
    AST_FLAG_LATCH: assert property ((monitoring_w && |lane_flags_i.tx_fault && !reset_held_w)
        |=> ((flags_r.tx_fault & $past(lane_flags_i.tx_fault)) == $past(lane_flags_i.tx_fault)))
        else $error("transmit fault not latched");
    AST_THRESH: assert property ((monitoring_w && !reset_held_w &&
        (diag_monitor_i[NUM_MON-1] > msbc_pkg::ALARM_HI[msbc_pkg::MON_KIND[NUM_MON-1]]))
        |=> alarm_r[NUM_MON-1])
        else $error("temperature alarm not flagged");
    AST_WRITE_EQ: assert property ((wr_w && (addr_w == msbc_pkg::CTRL_ADDR[msbc_pkg::CI_TX_EQ]))
        |=> link_ctrl_o.tx_eq[7:0] == $past(mgmt_req_i.wdata))
        else $error("equalizer write lost");
    AST_NOT_READY: assert property (reset_held_w |=> not_ready_r [*2])
        else $error("not-ready not held during reset");

    COV_POWERUP: cover property ($fell(not_ready_r));
    COV_RELEASE: cover property (rd_status_w && reset_done_r && !not_ready_r);
    COV_HIGH_POWER: cover property ($rose(high_power_o));
    COV_FLAG_INT: cover property (flag_int_w && !reset_done_r);

endmodule

// *** tb_msbc_sideband.sv ***
// self-checking bench for the sideband control block
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) \
        begin \
            $display("BAD %s exp %0h got %0h", nm, ex, got); \
            n_mismatch++; \
        end \
    end
module tb_msbc_sideband;
    logic clk_sys_i;
    logic arst_n_i;
    msbc_pkg::msbc_lane_flags_s lane_flags;
    logic [msbc_pkg::NUM_MON-1:0][15:0] diag;
    msbc_pkg::msbc_mgmt_req_s req;
    msbc_pkg::msbc_link_ctrl_s lc;
    logic sel_n, rst_n, lp_req, ack_w, present_n, int_drv, oe_n, hp;
    logic [7:0] rdat;
    wire int_pin = oe_n ? 1'b1 : int_drv;
    int n_mismatch, compares, seed, i, b;
    logic ack;
    logic [7:0] rd, v, hi;
    logic [7:0] ce [msbc_pkg::NUM_CTRL];

    msbc_sideband dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .module_select_n_i(sel_n),
        .module_reset_n_i(rst_n), .low_power_request_i(lp_req), .lane_flags_i(lane_flags),
        .diag_monitor_i(diag), .mgmt_req_i(req), .mgmt_ack_o(ack_w), .mgmt_rdata_o(rdat),
        .module_present_n_o(present_n), .interrupt_n_o(int_drv),
        .interrupt_n_oe_n_o(oe_n), .high_power_o(hp), .link_ctrl_o(lc));
    msbc_host_model host (.clk_sys_i(clk_sys_i), .mgmt_ack_i(ack_w), .mgmt_rdata_i(rdat),
        .module_select_n_o(sel_n), .module_reset_n_o(rst_n),
        .low_power_request_o(lp_req), .mgmt_req_o(req));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [47:0] exp_fields();
        return {ce[4], ce[3], ce[6], ce[5], ce[8], ce[7]};
    endfunction
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic mrd(input logic [7:0] a);
        host.xfer(1'b0, 1'b0, a, 8'h00, ack, rd);
    endtask
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b0, 1'b1, a, d, ack, rd);
    endtask
    task automatic wait_int(input int lim);
        int k;
        k = 0;
        while (oe_n !== 1'b0 && k < lim)
        begin
            tick(1);
            k++;
        end
        if (oe_n !== 1'b0)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // monitors inside every warning window
    task automatic safe_diag();
        for (int j = 0; j < msbc_pkg::NUM_MON; j++)
            diag[j] = (j == 12) ? 16'h8000 : 16'h0800;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        compares = 0;
        seed = 70;
        arst_n_i = 1'b0;
        lane_flags = '0;
        safe_diag();
        ce = msbc_pkg::CTRL_RST;
        tick(12);
        arst_n_i = 1'b1;
        tick(1);
        `CHK("present", 1'b0, present_n);
        `CHK("high power", 1'b0, hp);
        `CHK("clock recovery", 8'hff, {lc.clock_recovery_tx_en, lc.clock_recovery_rx_en});
        `CHK("fields", exp_fields(), {lc.tx_eq, lc.rx_emph, lc.rx_amp});
        mrd(msbc_pkg::ADDR_STATUS);
        `CHK("init ack", 1'b1, ack);
        `CHK("not ready", 8'h01, rd);
        wait_int(300);
        `CHK("int pin", 1'b0, int_pin);
        mrd(msbc_pkg::ADDR_STATUS);
        `CHK("ready", 8'h00, rd);
        tick(1);
        `CHK("int release", 1'b1, oe_n);
        host.xfer(1'b1, 1'b1, msbc_pkg::CTRL_ADDR[msbc_pkg::CI_TX_EQ], 8'h5a, ack, rd);
        `CHK("unselected ack", 1'b0, ack);
        `CHK("unselected write", exp_fields(), {lc.tx_eq, lc.rx_emph, lc.rx_amp});
        for (i = msbc_pkg::CI_TX_EQ; i < msbc_pkg::NUM_CTRL; i++)
        begin
            v = 8'($random(seed));
            ce[i] = v;
            mwr(msbc_pkg::CTRL_ADDR[i], v);
            `CHK("field write", exp_fields(), {lc.tx_eq, lc.rx_emph, lc.rx_amp});
        end
        mwr(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_CLKREC], 8'h00);
        `CHK("clock recovery off", 8'h00, {lc.clock_recovery_tx_en, lc.clock_recovery_rx_en});
        // masked group raises no interrupt
        mwr(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_MASK], 8'h19);
        lane_flags.signal_absent_flag = 4'h1;
        tick(1);
        lane_flags = '0;
        tick(4);
        `CHK("masked flag", 1'b1, oe_n);
        mrd(msbc_pkg::ADDR_SIG_ABSENT);
        mwr(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_MASK], 8'h18);
        tick(1);
        for (i = 0; i < 3; i++)
        begin
            b = $random(seed) & 3;
            lane_flags[(2 - i) * 4 + b] = 1'b1;
            tick(1);
            lane_flags = '0;
            wait_int(4);
            `CHK("flag int", 1'b0, int_pin);
            mrd(msbc_pkg::ADDR_SIG_ABSENT + i[7:0]);
            `CHK("flag byte", 8'h01 << b, rd);
            tick(1);
            `CHK("flag cleared", 1'b1, oe_n);
        end
        for (i = 0; i < msbc_pkg::NUM_MON; i++)
        begin
            diag[i] = 16'($random(seed));
            mrd(msbc_pkg::ADDR_MON_BASE + 8'(2 * i));
            hi = rd;
            mrd(msbc_pkg::ADDR_MON_BASE + 8'(2 * i + 1));
            `CHK("monitor", diag[i], {hi, rd});
        end
        mwr(msbc_pkg::ADDR_MON_BASE, ~diag[0][15:8]);
        mrd(msbc_pkg::ADDR_MON_BASE);
        `CHK("monitor write", diag[0][15:8], rd);
        diag[13] = 16'hffff;
        tick(1);
        mrd(msbc_pkg::ADDR_ALARM_HI);
        `CHK("temp alarm", 1'b1, rd[5]);
        safe_diag();
        mrd(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_POWER]);
        `CHK("power byte", 8'h00, rd);
        host.low_power_request_o = 1'b0;
        tick(1);
        `CHK("pin high power", 1'b1, hp);
        host.low_power_request_o = 1'b1;
        tick(1);
        `CHK("pin low power", 1'b0, hp);
        for (i = 1; i < 4; i++)
        begin
            mwr(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_POWER], i[7:0]);
            tick(1);
            `CHK("override power", i == 3, hp);
        end
        // short pulse leaves settings alone
        host.module_reset_n_o = 1'b0;
        tick(100);
        host.module_reset_n_o = 1'b1;
        tick(2);
        `CHK("short reset", exp_fields(), {lc.tx_eq, lc.rx_emph, lc.rx_amp});
        host.module_reset_n_o = 1'b0;
        tick(msbc_pkg::RESET_MIN_CYC + 3);
        ce = msbc_pkg::CTRL_RST;
        `CHK("pin reset fields", exp_fields(), {lc.tx_eq, lc.rx_emph, lc.rx_amp});
        `CHK("pin reset recovery", 8'hff, {lc.clock_recovery_tx_en, lc.clock_recovery_rx_en});
        `CHK("pin reset power", 1'b0, hp);
        mrd(msbc_pkg::ADDR_STATUS);
        `CHK("reset not ready", 8'h01, rd);
        mwr(msbc_pkg::CTRL_ADDR[msbc_pkg::CI_TX_EQ], 8'h77);
        `CHK("held write", 16'h0000, lc.tx_eq);
        host.module_reset_n_o = 1'b1;
        wait_int(300);
        mrd(msbc_pkg::ADDR_STATUS);
        `CHK("reset ready", 8'h00, rd);
        tick(1);
        `CHK("reset int release", 1'b1, oe_n);
        tally_and_finish();
    end
endmodule
